// [hw/hbg_gate_control.sv]
// H-bridge gate control with fault shutdown, short latches and Avalon registers
`timescale 1ns/100ps
module hbg_gate_control #(
    parameter int SHORT_DETECT_CYCLES = hbg_pkg::SHORT_DETECT_CYC,
    parameter int WAKE_CYCLES = hbg_pkg::WAKE_CYC
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic dir_sel_in = 1'b1,
    input wire logic pwm_in = 1'b1,
    input wire hbg_pkg::hbg_faults_s fault_flags_in,
    input wire logic bridge_node_1_above_in,
    input wire logic bridge_node_2_above_in,
    input wire logic fault_n_in,
    output hbg_pkg::hbg_gates_s gate_drive_out,
    output logic gate_oe_out,
    output logic fault_n_out,
    output logic fault_n_oe_out,
    output logic kline_tx_disable_out,
    output logic irq_out,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    import hbg_pkg::*;

    generate
        if (SHORT_DETECT_CYCLES < 1 || SHORT_DETECT_CYCLES >= (1 << CNT_W) - 1) begin : g_chk_sd
            $error("SHORT_DETECT_CYCLES out of range");
        end
        if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_W)) begin : g_chk_wk
            $error("WAKE_CYCLES out of range");
        end
    endgenerate

    // Normal bridge decode
    function automatic hbg_gates_s decode(input logic dir, input logic pwm);
        hbg_gates_s g;
        g = GATES_SINK;
        if (pwm) begin
            g.ls1_gate = 1'b1;
            g.ls2_gate = 1'b1;
        end else if (dir) begin
            g.hs1_gate = 1'b1;
            g.ls2_gate = 1'b1;
        end else begin
            g.hs2_gate = 1'b1;
            g.ls1_gate = 1'b1;
        end
        return g;
    endfunction

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Input synchronisers
    logic [SY_N-1:0] raw;
    logic [SY_N-1:0] sy1;
    logic [SY_N-1:0] sy2;
    logic [SY_N-1:0] sy3;
    logic [SY_N-1:0] filt;

    assign raw[SY_EN] = enable_in;
    assign raw[SY_DIR] = dir_sel_in;
    assign raw[SY_PWM] = pwm_in;
    assign raw[SY_TEMP] = fault_flags_in.over_temp_flag;
    assign raw[SY_OVOLT] = fault_flags_in.over_volt_flag;
    assign raw[SY_UVOLT] = fault_flags_in.under_volt_flag;
    assign raw[SY_NODE1] = bridge_node_1_above_in;
    assign raw[SY_NODE2] = bridge_node_2_above_in;

    generate
        for (genvar s = 0; s < SY_N; s++) begin : g_sync
            // Second and third stage must agree, which rejects a single metastable sample
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    sy1[s] <= 1'b0;
                    sy2[s] <= 1'b0;
                    sy3[s] <= 1'b0;
                    filt[s] <= 1'b0;
                end else begin
                    sy1[s] <= raw[s];
                    sy2[s] <= sy1[s];
                    sy3[s] <= sy2[s];
                    if (sy2[s] == sy3[s]) begin
                        filt[s] <= sy3[s];
                    end
                end
            end
        end
    endgenerate

    logic enabled;
    logic dir_sel;
    logic pwm;
    logic node1_above;
    logic node2_above;
    hbg_faults_s faults;
    logic supply_fault;
    assign enabled = filt[SY_EN];
    assign dir_sel = filt[SY_DIR];
    assign pwm = filt[SY_PWM];
    assign node1_above = filt[SY_NODE1];
    assign node2_above = filt[SY_NODE2];
    assign faults = {filt[SY_UVOLT], filt[SY_OVOLT], filt[SY_TEMP]};
    assign supply_fault = |faults;

    // Control input change detection
    logic dir_prev;
    logic pwm_prev;
    logic ctrl_change;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_prev <= 1'b0;
            pwm_prev <= 1'b0;
        end else begin
            dir_prev <= dir_sel;
            pwm_prev <= pwm;
        end
    end
    assign ctrl_change = (dir_sel != dir_prev) || (pwm != pwm_prev);

    // Wake-up timer; host waits on it, the bridge does not
    logic [CNT_W-1:0] wake_cnt;
    logic awake;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_cnt <= '0;
        end else if (!enabled) begin
            wake_cnt <= '0;
        end else if (wake_cnt != CNT_W'(WAKE_CYCLES)) begin
            wake_cnt <= wake_cnt + 1'b1;
        end
    end
    assign awake = (wake_cnt == CNT_W'(WAKE_CYCLES));

    // Short detection per transistor
    logic [CNT_W-1:0] detect_cfg;
    hbg_gates_s normal;
    hbg_gates_s cmd_on;
    logic [G_N-1:0] latch;
    logic [G_N-1:0] short_cond;
    logic [G_N-1:0] latch_set;
    logic [CNT_W-1:0] short_cnt [G_N];

    assign normal = decode(dir_sel, pwm);

    generate
        for (genvar i = 0; i < G_N; i++) begin : g_short
            localparam bit IS_HS = (i == G_HS1) || (i == G_HS2);
            localparam bit ON_NODE1 = (i == G_HS1) || (i == G_LS1);
            logic node_above;
            assign node_above = ON_NODE1 ? node1_above : node2_above;
            // High side shorted when node stays low, low side when it stays high
            assign short_cond[i] = IS_HS ? !node_above : node_above;
            assign cmd_on[i] = enabled && !supply_fault && normal[i] && !latch[i];
            assign latch_set[i] = cmd_on[i] && short_cond[i] && (short_cnt[i] >= detect_cfg);

            // Saturating count, so a stuck comparator cannot wrap and re-arm
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    short_cnt[i] <= '0;
                end else if (!(cmd_on[i] && short_cond[i])) begin
                    short_cnt[i] <= '0;
                end else if (short_cnt[i] != {CNT_W{1'b1}}) begin
                    short_cnt[i] <= short_cnt[i] + 1'b1;
                end
            end

            // A new short beats a simultaneous control change
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    latch[i] <= 1'b0;
                end else if (latch_set[i]) begin
                    latch[i] <= 1'b1;
                end else if (ctrl_change) begin
                    latch[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Gate drive with fault priority
    hbg_gates_s next_gates;
    logic next_fault_n;
    always_comb begin
        next_gates = GATES_SINK;
        next_fault_n = 1'b1;
        if (!enabled) begin
            next_gates = GATES_SINK;
        end else if (supply_fault) begin
            next_gates = GATES_SINK;
            next_fault_n = 1'b0;
        end else begin
            next_gates = normal & ~latch;
            next_fault_n = ~|latch;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gate_drive_out <= GATES_SINK;
            gate_oe_out <= 1'b0;
        end else begin
            gate_drive_out <= next_gates;
            gate_oe_out <= enabled;
        end
    end

    // Open-drain diagnostic pin, undriven in standby
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_n_out <= 1'b1;
            fault_n_oe_out <= 1'b0;
        end else begin
            fault_n_out <= next_fault_n;
            fault_n_oe_out <= enabled;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            kline_tx_disable_out <= 1'b0;
        end else begin
            kline_tx_disable_out <= enabled &&
                (faults.over_temp_flag || faults.over_volt_flag);
        end
    end

    // Fault events for the interrupt status
    // Rising edges only, so a fault that stays on reports once
    hbg_faults_s faults_prev;
    logic [STAT_W-1:0] events;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            faults_prev <= '0;
        end else begin
            faults_prev <= faults;
        end
    end
    assign events[STAT_TEMP] = faults.over_temp_flag && !faults_prev.over_temp_flag;
    assign events[STAT_OVOLT] = faults.over_volt_flag && !faults_prev.over_volt_flag;
    assign events[STAT_UVOLT] = faults.under_volt_flag && !faults_prev.under_volt_flag;
    assign events[STAT_SHORT] = |latch_set;

    // Avalon slave: one wait cycle, then the access completes
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic done;
    logic [31:0] next_rdata;
    logic [31:0] mask_merged;
    logic [31:0] detect_merged;
    assign done = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    // Merged words as nets, so only the implemented bits are kept
    assign mask_merged = merge(32'(mask), avs_writedata_in, avs_byteenable_in);
    assign detect_merged = merge(32'(detect_cfg), avs_writedata_in, avs_byteenable_in);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    always_comb begin
        next_rdata = '0;
        unique case (avs_address_in)
            REG_STATUS: next_rdata[STAT_W-1:0] = status;
            REG_MASK: next_rdata[STAT_W-1:0] = mask;
            REG_LIVE: begin
                next_rdata[LV_FAULT_LSB +: 3] = faults;
                next_rdata[LV_LATCH_LSB +: G_N] = latch;
                next_rdata[LV_ENABLED] = enabled;
                next_rdata[LV_AWAKE] = awake;
                next_rdata[LV_PIN] = fault_n_in;
                next_rdata[LV_DIR] = dir_sel;
                next_rdata[LV_PWM] = pwm;
            end
            REG_DETECT: next_rdata[CNT_W-1:0] = detect_cfg;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= '0;
        end else if (avs_read_in && avs_waitrequest_out) begin
            avs_readdata_out <= next_rdata;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask <= MASK_RESET;
            detect_cfg <= CNT_W'(SHORT_DETECT_CYCLES);
        end else if (done && avs_write_in) begin
            if (avs_address_in == REG_MASK) begin
                mask <= mask_merged[STAT_W-1:0];
            end
            if (avs_address_in == REG_DETECT) begin
                detect_cfg <= detect_merged[CNT_W-1:0];
            end
        end
    end

    // Sticky status: read clears only the bits it reported
    // A bit set after read data was captured survives, as does a same-cycle event
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status <= '0;
        end else if (done && avs_read_in && avs_address_in == REG_STATUS) begin
            status <= (status & ~avs_readdata_out[STAT_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status & mask);
        end
    end
endmodule

// [include/hbg_pkg.sv]
// Constants, types and overview of the H-bridge gate control block
// Overview of operation
// - Enable low: all gates resistive, fault_n undriven, other inputs ignored; fault flags still set status bits and can raise irq.
// - Gates follow dir_sel and PWM only while enable is high.
// - Unconnected dir_sel or PWM input reads as logic high.
// - Dir low, PWM low: hs2 and ls1 source, hs1 and ls2 sink, fault_n high.
// - Dir high, PWM low: hs1 and ls2 source, ls1 and hs2 sink, fault_n high.
// - PWM high: both low sides source, both high sides sink, fault_n high.
// - Over-temperature: all gates sink, K-line disabled, fault_n low until cleared; not latched, fault_n rises once the flag drops.
// - Overvoltage: all gates sink, K-line disabled, fault_n low.
// - Undervoltage: all gates sink, fault_n low.
// - High side on with node below threshold too long: switch off, flag short.
// - Low side on with node above threshold too long: switch off, flag short.
// - Only shorted transistors turn off; others keep the normal decode.
// - Short latch holds gate off and fault_n low until dir_sel or PWM changes.
// - fault_n low whenever any shutdown is present, high otherwise while enabled.
package hbg_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SHORT_DETECT_NS = 10000;
    localparam int SHORT_DETECT_CYC = (SHORT_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_NS = 50000;
    localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int SYNC_STAGES = 3;

    // Register byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_LIVE = 4'h8;
    localparam logic [3:0] REG_DETECT = 4'hC;

    // Status and mask layout
    localparam int STAT_TEMP = 0;
    localparam int STAT_OVOLT = 1;
    localparam int STAT_UVOLT = 2;
    localparam int STAT_SHORT = 3;
    localparam int STAT_W = 4;
    localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;

    // Live register layout
    localparam int LV_FAULT_LSB = 0;
    localparam int LV_LATCH_LSB = 3;
    localparam int LV_ENABLED = 7;
    localparam int LV_AWAKE = 8;
    localparam int LV_PIN = 9;
    localparam int LV_DIR = 10;
    localparam int LV_PWM = 11;

    // Synchroniser lanes
    localparam int SY_EN = 0;
    localparam int SY_DIR = 1;
    localparam int SY_PWM = 2;
    localparam int SY_TEMP = 3;
    localparam int SY_OVOLT = 4;
    localparam int SY_UVOLT = 5;
    localparam int SY_NODE1 = 6;
    localparam int SY_NODE2 = 7;
    localparam int SY_N = 8;

    // Gate bit positions within hbg_gates_s
    localparam int G_LS2 = 0;
    localparam int G_HS2 = 1;
    localparam int G_LS1 = 2;
    localparam int G_HS1 = 3;
    localparam int G_N = 4;

    // One bit per gate: 1 source, 0 sink
    typedef struct packed {
        logic hs1_gate;
        logic ls1_gate;
        logic hs2_gate;
        logic ls2_gate;
    } hbg_gates_s;

    typedef struct packed {
        logic under_volt_flag;
        logic over_volt_flag;
        logic over_temp_flag;
    } hbg_faults_s;

    localparam hbg_gates_s GATES_SINK = '{default: 1'b0};
endpackage

// [sim/hbg_host.sv]
// Host-side model driving the enable, direction and PWM pins
`timescale 1ns/100ps
module hbg_host #(
    parameter int WAKE = 8
) (
    input wire logic clock_in,
    input wire logic en_req_in,
    input wire logic dir_req_in,
    input wire logic pwm_req_in,
    input wire logic loose_in,
    output logic enable_out,
    output logic dir_out,
    output logic pwm_out
);
    int cnt = 0;
    initial begin
        enable_out = 1'b0;
        dir_out = 1'b1;
        pwm_out = 1'b1;
    end
    always @(posedge clock_in) begin
        if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if (en_req_in != enable_out) begin
            // Park both pins high before the enable edge
            dir_out <= 1'b1;
            pwm_out <= 1'b1;
            if (en_req_in || (dir_out && pwm_out)) begin
                enable_out <= en_req_in;
                cnt <= en_req_in ? WAKE : 0;
            end
        end else if (enable_out) begin
            pwm_out <= pwm_req_in;
            // Loose mode lets the bench brake with direction low
            dir_out <= (pwm_req_in && !loose_in) ? 1'b1 : dir_req_in;
        end
    end
endmodule

// [sim/hbg_gate_control_assertions.sv]
// Port-level assertions for the gate control block
`timescale 1ns/100ps
module hbg_chk #(
    parameter int SHORT_DETECT_CYCLES = 4,
    parameter int WAKE_CYCLES = 8
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic dir_sel_in,
    input wire logic pwm_in,
    input wire hbg_pkg::hbg_faults_s fault_flags_in,
    input wire hbg_pkg::hbg_gates_s gate_drive_out,
    input wire logic gate_oe_out,
    input wire logic fault_n_out,
    input wire logic fault_n_oe_out,
    input wire logic kline_tx_disable_out,
    input wire logic irq_out,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_waitrequest_out
);
    import hbg_pkg::*;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    // Eight cycles cover sync latency with margin
    sequence s_run(d, p);
        (enable_in && fault_flags_in == 3'h0 && dir_sel_in == d && pwm_in == p) [*8];
    endsequence
    property p_standby;
        (!enable_in) [*8] |-> !gate_oe_out && !fault_n_oe_out && gate_drive_out == GATES_SINK;
    endproperty
    a_standby: assert property (p_standby) else $error("gates driven in standby");
    property p_fwd;
        s_run(0, 0) ##0 fault_n_out |-> gate_oe_out && gate_drive_out == 4'h6;
    endproperty
    a_fwd: assert property (p_fwd) else $error("wrong forward decode");
    property p_rev;
        s_run(1, 0) ##0 fault_n_out |-> gate_oe_out && gate_drive_out == 4'h9;
    endproperty
    a_rev: assert property (p_rev) else $error("wrong reverse decode");
    property p_brake;
        s_run(1, 1) ##0 fault_n_out |-> gate_drive_out == 4'h5;
    endproperty
    a_brake: assert property (p_brake) else $error("wrong brake decode");
    property p_fault;
        (enable_in && fault_flags_in != 3'h0) [*8] |->
            gate_drive_out == GATES_SINK && !fault_n_out && fault_n_oe_out;
    endproperty
    a_fault: assert property (p_fault) else $error("gates on during fault");
    property p_kline;
        (enable_in && (fault_flags_in.over_temp_flag || fault_flags_in.over_volt_flag)) [*8]
            |-> kline_tx_disable_out;
    endproperty
    a_kline: assert property (p_kline) else $error("transmitter not disabled");
    property p_all_off;
        gate_oe_out && gate_drive_out == GATES_SINK |-> !fault_n_out;
    endproperty
    a_all_off: assert property (p_all_off) else $error("all gates off, no fault shown");
    property p_unmask;
        avs_write_in && !avs_waitrequest_out && avs_address_in == REG_MASK &&
            avs_byteenable_in[0] && avs_writedata_in[3:0] == 4'h0 |-> ##2 !irq_out;
    endproperty
    a_unmask: assert property (p_unmask) else $error("irq stays with mask clear");
    property p_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=>
            !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer not after one wait");
    c_short: cover property (fault_flags_in == 3'h0 && fault_n_oe_out && $fell(fault_n_out));
    c_irq: cover property ($rose(irq_out));
    c_kline: cover property ($rose(kline_tx_disable_out));
endmodule
bind hbg_gate_control hbg_chk #(.SHORT_DETECT_CYCLES(SHORT_DETECT_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)) chk_u (.clock_in, .rst_n_in, .enable_in, .dir_sel_in,
    .pwm_in, .fault_flags_in, .gate_drive_out, .gate_oe_out, .fault_n_out, .fault_n_oe_out,
    .kline_tx_disable_out, .irq_out, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out);

// [sim/testbench.sv]
// Self-checking bench for the gate control block
`timescale 1ns/100ps
module testbench;
    import hbg_pkg::*;
    localparam int DET = 20;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic en_req = 1'b0;
    logic dir_req = 1'b1;
    logic pwm_req = 1'b1;
    logic loose = 1'b0;
    logic en_w, dir_w, pwm_w, oe, fn, fn_oe, kline, irq, waitreq;
    logic node1 = 1'b0;
    logic node2 = 1'b0;
    logic inj1 = 1'b0;
    logic inj2 = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic [31:0] seed = 32'h41AD481B;
    hbg_faults_s flags = 3'h0;
    hbg_gates_s gates;
    int n_mismatch = 0;
    int checks = 0;
    // Open-drain diagnostic wire with pull-up
    wire fault_wire = fn_oe ? fn : 1'b1;
    hbg_host #(.WAKE(8)) host_u (.clock_in, .en_req_in(en_req), .dir_req_in(dir_req),
        .pwm_req_in(pwm_req), .loose_in(loose), .enable_out(en_w), .dir_out(dir_w),
        .pwm_out(pwm_w));
    hbg_gate_control #(.SHORT_DETECT_CYCLES(DET), .WAKE_CYCLES(8)) dut_u (.clock_in,
        .rst_n_in, .enable_in(en_w), .dir_sel_in(dir_w), .pwm_in(pwm_w),
        .fault_flags_in(flags), .bridge_node_1_above_in(node1),
        .bridge_node_2_above_in(node2), .fault_n_in(fault_wire), .gate_drive_out(gates),
        .gate_oe_out(oe), .fault_n_out(fn), .fault_n_oe_out(fn_oe),
        .kline_tx_disable_out(kline), .irq_out(irq), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(waitreq));
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    // Healthy bridge: node high while its high side conducts; inject flips it
    always @(posedge clock_in) begin
        node1 <= gates.hs1_gate ^ inj1;
        node2 <= gates.hs2_gate ^ inj2;
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function int dec(int d, int p);
        return p ? 5 : (d ? 9 : 6);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task look(input int n, input int o, input int g, input int f, input int k);
        repeat (n) @(posedge clock_in);
        chk({25'h0, oe, gates, fault_wire, kline}, 32'(o * 64 + g * 4 + f * 2 + k));
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clock_in);
        // No timeout here; only the watchdog ends a stuck wait
        while (waitreq !== 1'b0) begin
            @(posedge clock_in);
        end
        q = rdat;
        chk(waitreq, 0);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock_in);
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock_in);
        n_mismatch++;
        summarize();
    end
    initial begin
        logic [31:0] r;
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        bus(0, REG_MASK, 0);
        chk(q, MASK_RESET);
        bus(0, REG_DETECT, 0);
        chk(q, DET);
        bus(0, 4'h2, 0);
        chk(q, 0);
        bus(1, REG_MASK, 32'hF);
        flags <= 3'(rnd());
        look(12, 0, 0, 1, 0);
        flags <= 3'h0;
        bus(0, REG_STATUS, 0);
        en_req <= 1'b1;
        look(24, 1, 5, 1, 0);
        // Enabled, awake, pin high, dir and pwm parked high, no fault or latch
        bus(0, REG_LIVE, 0);
        chk(q, 32'hF80);
        loose <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            dir_req <= i[0];
            pwm_req <= i[1];
            look(12, 1, dec(i % 2, i / 2), 1, 0);
        end
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            dir_req <= r[0];
            pwm_req <= r[1];
            flags <= 3'(1 << k);
            look(12, 1, 0, 0, k < 2 ? 1 : 0);
            chk(irq, 1);
            bus(0, REG_STATUS, 0);
            chk(q, 1 << k);
            flags <= 3'h0;
            look(12, 1, dec(r[0], r[1]), 1, 0);
            chk(irq, 0);
        end
        loose <= 1'b0;
        dir_req <= 1'b0;
        pwm_req <= 1'b0;
        look(12, 1, 6, 1, 0);
        inj2 <= 1'b1;
        look(40, 1, 4, 0, 0);
        inj2 <= 1'b0;
        look(40, 1, 4, 0, 0);
        chk(irq, 1);
        bus(1, REG_MASK, 0);
        @(posedge clock_in);
        chk(irq, 0);
        bus(0, REG_STATUS, 0);
        chk(q, 8);
        pwm_req <= 1'b1;
        look(12, 1, 5, 1, 0);
        pwm_req <= 1'b0;
        inj1 <= 1'b1;
        look(40, 1, 2, 0, 0);
        inj1 <= 1'b0;
        dir_req <= 1'b1;
        look(12, 1, 9, 1, 0);
        en_req <= 1'b0;
        look(16, 0, 0, 1, 0);
        summarize();
    end
endmodule
